// ---- verilog/watchdog_control_logic.sv ----
/*
 * Watchdog supervisor: control register, 16-bit timeout counter,
 * reset or interrupt on expiry, protected two-step write.
 * Assumes a one-cycle 32.768 kHz tick synchronous to i_clk, a pulse
 * at the end of every core instruction, and core writes that pulse
 * together with the end of their own instruction.
 */
`timescale 1ns/1ps
`include "watchdog_defs.svh"

// Contract
// [R1] timeout is two to the prescale times 512 ticks, codes 0..7.
// [R2] code 1000 gives immediate reset; codes 1001 and up reserved.
// [R3] interrupt select turns expiry into an unmaskable interrupt.
// [R4] interrupt mode serves as periodic timer at prescale interval.
// [R5] any timeout sets the status flag.
// [R6] status clears only by written zero or hardware reset.
// [R7] setting enable restarts counter; software must re-set in time.
// [R8] enable cleared by zero write, watchdog reset, reset, supply irq.
// [R9] control write accepted only right after setting write unlock.
// [R10] counter is sixteen bits counting 32.768 kHz ticks.
// [R11] control resets to 10H and is bit addressable.
// [R12] unprotected writes ignored; unlock clears after protected write.
// [R13] software disables interrupts around the two-step write.
module watchdog_control_logic (
   // clock and reset
   input  wire logic                   i_clk,
   input  wire logic                   i_srst,
   // timebase and core sequencing
   input  wire logic                   i_tick_32k,
   input  wire logic                   i_instr_end,
   // special function register access
   input  wire logic                   i_byte_wr,
   input  wire watchdog_pkg::ctrl_t    i_wdata,
   input  wire logic                   i_bit_wr,
   input  wire logic [2:0]             i_bit_sel,
   input  wire logic                   i_bit_val,
   output watchdog_pkg::ctrl_t         o_rdata,
   // supply monitor
   input  wire logic                   i_supply_irq,
   // timeout actions
   output logic                        o_wdt_reset,
   output logic                        o_wdt_irq
);
   import watchdog_pkg::*;

   // ****************************************************
   // register state
   // ****************************************************
   ctrl_t        ctrl_reg;
   wd_count_t    count_reg;
   logic         rst_pulse_reg;
   logic         irq_pulse_reg;

   ctrl_t        wr_data;
   logic         wr_any;
   logic         arm;
   logic         accept;
   prescale_t    prescale;
   logic         enable;
   logic         irq_sel;
   logic         pending;
   logic [16:0]  span;
   wd_count_t    limit;
   logic         hit;
   timeout_act_e action;

   assign prescale = ctrl_reg[`WDC_PRE_MSB:`WDC_PRE_LSB];
   assign enable   = ctrl_reg[`WDC_BIT_ENABLE];
   assign irq_sel  = ctrl_reg[`WDC_BIT_IRQ_SEL];
   assign pending  = ctrl_reg[`WDC_BIT_UNLOCK];

   // ****************************************************
   // write decode
   // ****************************************************
   // [R11] bit writes merge into the current value
   always_comb begin
      wr_data = i_wdata;
      if (i_bit_wr) begin
         wr_data = ctrl_reg;
         wr_data[i_bit_sel] = i_bit_val;
      end
   end

   assign wr_any = i_byte_wr | i_bit_wr;
   // [R9] first step only raises the unlock bit
   assign arm    = wr_any & ~pending & wr_data[`WDC_BIT_UNLOCK];
   // [R12] only the write straight after unlocking counts
   assign accept = wr_any & pending;

   // ****************************************************
   // timeout detect
   // ****************************************************
   // [R1] span of 512 ticks shifted by the prescale code
   assign span  = 17'(`WDC_BASE_TICKS) << prescale[2:0];
   assign limit = 16'(span - 17'h00001);

   // [R2] reserved codes are treated as immediate, the safe side
   always_comb begin
      hit = 1'b0;
      if (enable) begin
         if (prescale >= `WDC_PRE_IMMEDIATE)
            hit = 1'b1;
         else
            hit = i_tick_32k & (count_reg == limit);
      end
   end

   // [R3] interrupt select decides the action
   always_comb begin
      if (!hit)
         action = act_none;
      else if (irq_sel)
         action = act_irq;
      else
         action = act_reset;
   end

   // ****************************************************
   // control register
   // ****************************************************
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         // [R11] power-on value
         ctrl_reg <= `WDC_RESET_VALUE;
      end else begin
         // [R6] status drops only by accepted write
         if (accept) begin
            ctrl_reg <= wr_data;
         end
         // [R12] unlock lasts one instruction only
         if (arm)
            ctrl_reg[`WDC_BIT_UNLOCK] <= 1'b1;
         else if (i_instr_end || accept)
            ctrl_reg[`WDC_BIT_UNLOCK] <= 1'b0;
         // [R8] hardware clears beat a software set
         if (action == act_reset || i_supply_irq)
            ctrl_reg[`WDC_BIT_ENABLE] <= 1'b0;
         // [R5] set wins over a written zero
         if (hit)
            ctrl_reg[`WDC_BIT_STATUS] <= 1'b1;
      end
   end

   // ****************************************************
   // timeout counter
   // ****************************************************
   // [R10] sixteen-bit counter on the slow tick
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         count_reg <= 16'h0000;
      end else if (!enable || hit) begin
         count_reg <= 16'h0000;
      end else if (accept && wr_data[`WDC_BIT_ENABLE]) begin
         // [R7] every set of enable starts a fresh period
         count_reg <= 16'h0000;
      end else if (i_tick_32k) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // ****************************************************
   // action pulses and read data
   // ****************************************************
   // [R4] interrupt mode leaves enable set, so it repeats
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rst_pulse_reg <= 1'b0;
         irq_pulse_reg <= 1'b0;
      end else begin
         rst_pulse_reg <= (action == act_reset);
         irq_pulse_reg <= (action == act_irq);
      end
   end

   assign o_wdt_reset = rst_pulse_reg;
   assign o_wdt_irq   = irq_pulse_reg;
   assign o_rdata     = ctrl_reg;

   // ****************************************************
   // checks
   // ****************************************************
   sequence s_expiry;
      enable && prescale < `WDC_PRE_IMMEDIATE && i_tick_32k
         && count_reg == limit;
   endsequence

   sequence s_irq_hit;
      hit && irq_sel && !i_supply_irq && !accept;
   endsequence

   property p_period;
      @(posedge i_clk) disable iff (i_srst)
      s_expiry |=> (o_wdt_reset || o_wdt_irq);
   endproperty
   a_period: assert property (p_period) // [R1]
      else $error("expiry gave no action");

   property p_immediate;
      @(posedge i_clk) disable iff (i_srst)
      enable && !irq_sel && prescale == `WDC_PRE_IMMEDIATE
         |=> o_wdt_reset && !enable;
   endproperty
   a_immediate: assert property (p_immediate) // [R2]
      else $error("immediate code did not reset");

   property p_irq_mode;
      @(posedge i_clk) disable iff (i_srst)
      hit && irq_sel |=> o_wdt_irq && !o_wdt_reset;
   endproperty
   a_irq_mode: assert property (p_irq_mode) // [R3]
      else $error("interrupt mode raised reset");

   property p_periodic;
      @(posedge i_clk) disable iff (i_srst)
      s_irq_hit |=> enable && count_reg == 16'h0000;
   endproperty
   a_periodic: assert property (p_periodic) // [R4]
      else $error("timer mode stopped after interrupt");

   property p_status_set;
      @(posedge i_clk) disable iff (i_srst)
      hit |=> ctrl_reg[`WDC_BIT_STATUS];
   endproperty
   a_status_set: assert property (p_status_set) // [R5]
      else $error("timeout did not set status");

   property p_status_clear;
      @(posedge i_clk) disable iff (i_srst)
      $fell(ctrl_reg[`WDC_BIT_STATUS]) |-> $past(accept);
   endproperty
   a_status_clear: assert property (p_status_clear) // [R6]
      else $error("status cleared without a write");

   property p_restart;
      @(posedge i_clk) disable iff (i_srst)
      accept && wr_data[`WDC_BIT_ENABLE] |=> count_reg == 16'h0000;
   endproperty
   a_restart: assert property (p_restart) // [R7]
      else $error("enable write did not restart counter");

   property p_enable_clear;
      @(posedge i_clk) disable iff (i_srst)
      o_wdt_reset || $past(i_supply_irq) |-> !enable;
   endproperty
   a_enable_clear: assert property (p_enable_clear) // [R8]
      else $error("enable survived a clearing event");

   property p_locked;
      @(posedge i_clk) disable iff (i_srst)
      !accept |=> $stable(prescale) && $stable(irq_sel);
   endproperty
   a_locked: assert property (p_locked) // [R9]
      else $error("control changed without unlock");

   property p_unlock_once;
      @(posedge i_clk) disable iff (i_srst)
      accept ##1 !arm |-> ##0 !pending;
   endproperty
   a_unlock_once: assert property (p_unlock_once) // [R12]
      else $error("unlock outlived protected write");

   property p_count_bound;
      @(posedge i_clk) disable iff (i_srst)
      enable && prescale < `WDC_PRE_IMMEDIATE |-> count_reg <= limit;
   endproperty
   a_count_bound: assert property (p_count_bound) // [R10]
      else $error("counter passed its limit");

endmodule : watchdog_control_logic

// ---- verilog/watchdog_defs.svh ----
/*
 * Offsets, field positions, reset value and timing figures of the
 * watchdog control logic.
 * Assumes inclusion by bare name.
 */
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

// ****************************************************
// control register layout
// ****************************************************
`define WDC_BIT_UNLOCK     0
`define WDC_BIT_ENABLE     1
`define WDC_BIT_STATUS     2
`define WDC_BIT_IRQ_SEL    3
`define WDC_PRE_LSB        4
`define WDC_PRE_MSB        7
`define WDC_RESET_VALUE    8'h10

// ****************************************************
// timing
// ****************************************************
`define WDC_TICK_HZ        32768
`define WDC_BASE_TICKS     512
`define WDC_PRE_IMMEDIATE  4'h8

`endif

// ---- verilog/watchdog_pkg.sv ----
/*
 * Types shared by the watchdog control logic.
 * Assumes nothing of its surroundings.
 */
package watchdog_pkg;

   typedef logic [3:0]  prescale_t;
   typedef logic [7:0]  ctrl_t;
   typedef logic [15:0] wd_count_t;

   typedef enum logic [1:0] {
      act_none,
      act_reset,
      act_irq
   } timeout_act_e;

endpackage : watchdog_pkg

// ---- sim/tb.sv ----
/*
 * Self-checking bench for the watchdog control logic.
 * Assumes the 32.768 kHz tick pulses every cycle, except in one 100-cycle pause, to shorten timeouts.
 */
`timescale 1ns/1ps

module tb;
   import watchdog_pkg::*;

   typedef struct packed {
      prescale_t   pre;
      logic        irq;
      logic [31:0] ticks;
   } row_s;

   logic        i_clk = 1'b0;
   logic        i_srst = 1'b1;
   logic        i_tick_32k = 1'b1;
   logic        i_instr_end = 1'b0;
   logic        i_byte_wr = 1'b0;
   ctrl_t       i_wdata = 8'h00;
   logic        i_bit_wr = 1'b0;
   logic [2:0]  i_bit_sel = 3'h0;
   logic        i_bit_val = 1'b0;
   logic        i_supply_irq = 1'b0;
   ctrl_t       o_rdata;
   logic        o_wdt_reset;
   logic        o_wdt_irq;
   int          mismatches = 0;
   int          cmp_count = 0;
   logic [31:0] n;
   logic        r;
   logic        q;
   row_s        rows [7] = '{
      '{4'h0, 1'b1, 32'd512},   '{4'h1, 1'b0, 32'd1024},
      '{4'h2, 1'b1, 32'd2048},  '{4'h3, 1'b0, 32'd4096},
      '{4'h4, 1'b0, 32'd8192},  '{4'h5, 1'b0, 32'd16384},
      '{4'h6, 1'b0, 32'd32768}};

   always #5 i_clk = ~i_clk;

   watchdog_control_logic dut (
      .i_clk        (i_clk),
      .i_srst       (i_srst),
      .i_tick_32k   (i_tick_32k),
      .i_instr_end  (i_instr_end),
      .i_byte_wr    (i_byte_wr),
      .i_wdata      (i_wdata),
      .i_bit_wr     (i_bit_wr),
      .i_bit_sel    (i_bit_sel),
      .i_bit_val    (i_bit_val),
      .o_rdata      (o_rdata),
      .i_supply_irq (i_supply_irq),
      .o_wdt_reset  (o_wdt_reset),
      .o_wdt_irq    (o_wdt_irq)
   );

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task rst(input int cyc);
      @(negedge i_clk);
      i_srst = 1'b1;
      repeat (cyc) @(negedge i_clk);
      i_srst = 1'b0;
   endtask : rst

   // set the unlock bit by a bit write, as its own instruction
   task arm;
      @(negedge i_clk);
      i_bit_wr = 1'b1;
      i_bit_sel = 3'h0;
      i_bit_val = 1'b1;
      i_instr_end = 1'b1;
   endtask : arm

   task wr(input ctrl_t b);
      @(negedge i_clk);
      i_bit_wr = 1'b0;
      i_byte_wr = 1'b1;
      i_wdata = b;
      i_instr_end = 1'b1;
      @(negedge i_clk);
      i_byte_wr = 1'b0;
      i_instr_end = 1'b0;
   endtask : wr

   task pwr(input ctrl_t b);
      // no other instruction between the two steps
      arm();
      wr(b);
   endtask : pwr

   // edges from the call until an action shows
   task wait_out;
      n = 0;
      r = 1'b0;
      q = 1'b0;
      while (r !== 1'b1 && q !== 1'b1 && n < 70000) begin
         @(posedge i_clk);
         #1;
         n++;
         r = o_wdt_reset;
         q = o_wdt_irq;
      end
   endtask : wait_out

   task print_verdict;
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   initial begin
      #1000000;
      mismatches++;
      print_verdict();
   end

   initial begin
      rst(20);
      chk(32'(o_rdata), 32'h10);
      wr(8'h72);
      chk(32'(o_rdata), 32'h10);
      // unlock lost when another instruction intervenes
      arm();
      @(negedge i_clk);
      i_bit_wr = 1'b0;
      wr(8'h72);
      chk(32'(o_rdata), 32'h10);
      // protected single-bit write merges into the register
      arm();
      @(negedge i_clk);
      i_bit_sel = 3'h3;
      @(negedge i_clk);
      i_bit_wr = 1'b0;
      i_instr_end = 1'b0;
      chk(32'(o_rdata), 32'h18);
      foreach (rows[k]) begin
         pwr({rows[k].pre, rows[k].irq, 3'b010});
         chk(32'(o_rdata), 32'({rows[k].pre, rows[k].irq, 3'b010}));
         wait_out();
         chk(n, rows[k].ticks);
         chk(32'({r, q}), 32'({~rows[k].irq, rows[k].irq}));
         chk(32'(o_rdata[2:1]), 32'({1'b1, rows[k].irq}));
         if (rows[k].irq) begin
            wait_out();
            chk(32'({n, q}), 32'({rows[k].ticks, 1'b1}));
         end
         pwr(8'h00);
         chk(32'(o_rdata), 32'h00);
      end
      // immediate code: reset next edge, status survives it
      pwr(8'h82);
      wait_out();
      chk(32'({n, r}), 32'({32'd1, 1'b1}));
      chk(32'(o_rdata), 32'h84);
      rst(2);
      chk(32'(o_rdata), 32'h10);
      // re-enabling mid-period restarts the full count
      pwr(8'h02);
      repeat (300) @(negedge i_clk);
      pwr(8'h02);
      // cycles without a tick must not count
      i_tick_32k = 1'b0;
      repeat (100) @(negedge i_clk);
      i_tick_32k = 1'b1;
      wait_out();
      chk(n, 32'd512);
      pwr(8'h0A);
      @(negedge i_clk);
      i_supply_irq = 1'b1;
      @(negedge i_clk);
      i_supply_irq = 1'b0;
      chk(32'(o_rdata), 32'h08);
      @(negedge i_clk);
      print_verdict();
   end
endmodule : tb
